// [core/slpc_top.sv]
// Sleep mode controller: sleep entry, clock gating and wake-up sequencing
// What this block does
// - Sleep is entered only on the sleep instruction; software picks mode and time.
// - After wake the interrupt is serviced, then execution resumes after sleep.
// - Pending higher-priority interrupts are serviced first, in priority order.
// - The processor is held halted four cycles after every wake-up.
// - Sleep leaves register file, RAM and all registers untouched.
// - Reset during sleep gives a full restart from the reset vector.
// - Enabled interrupts and reset sources wake the device, as the mode allows.
// - Idle stops processor and memory clocks; peripherals keep running.
// - Idle lets an ongoing memory programming operation finish.
// - Idle wakes on any enabled interrupt.
// - Power-down stops every clock but the memory clock during programming, real-time counter source included.
// - Power-down wakes only on two-wire address match or async port interrupts.
// - Power-save is power-down plus running counter and its wake interrupts.
// - Standby is power-down with system clock sources kept running.
// - Extended standby is power-save with system clock sources kept running.
// - A stopped system clock source adds its start-up time before resuming.
// - Per-peripheral gating freezes the peripheral and stops its clock.
// - Mode codes: idle 000, power-down 010, save 011, standby 110, ext 111.
// - The sleep instruction sleeps only while the sleep enable bit is set.
`include "slpc_consts.svh"

module slpc_top #(
  parameter int NPER = 8
) (
  // Clock and reset
  input  wire logic            CLK_I,
  input  wire logic            NRST_I,
  // Processor core
  input  wire logic            SLEEP_EXEC_I,
  input  wire logic [2:0]      SLEEP_MODE_SELECT_I,
  input  wire logic            SLEEP_ENABLE_BIT_I,
  output logic                 CPU_HALT_O,
  output logic                 WAKE_RESUME_O,
  output logic                 SLEEPING_O,
  // Interrupt controller and wake sources
  input  wire logic            IRQ_ANY_I,
  input  wire logic            RTC_IRQ_I,
  input  wire logic            RTC_ENABLE_I,
  input  wire logic            ASYNC_PORT_IRQ_I,
  input  wire logic            TWO_WIRE_INTERFACE_MATCH_I,
  // Memory and clock generator
  input  wire logic            NVM_BUSY_I,
  input  wire logic            SYS_OSC_READY_I,
  input  wire logic [NPER-1:0] PER_GATE_I,
  // Clock enables
  output slpc_pkg::slpc_clk_s  CLK_EN_O,
  output logic [NPER-1:0]      PER_CLK_EN_O
);

  // Parameter check at elaboration
  if (NPER < 1) begin : g_nper_chk
    $error("NPER must be at least 1");
  end

  slpc_pkg::slpc_regs_s r_r;
  slpc_pkg::slpc_regs_s r_nxt;

  // Mode code is one of the five defined ones
  function automatic logic mode_valid(input logic [2:0] m);
    mode_valid = (m == `SLPC_MODE_IDLE) || (m == `SLPC_MODE_POWER_DOWN_SETTING) ||
                 (m == `SLPC_MODE_POWER_SAVE_SETTING) || (m == `SLPC_MODE_STANDBY_SETTING) ||
                 (m == `SLPC_MODE_ESTBY);
  endfunction

  // Mode keeps the counter domain alive
  function automatic logic mode_rtc(input logic [2:0] m);
    mode_rtc = (m == `SLPC_MODE_IDLE) || (m == `SLPC_MODE_POWER_SAVE_SETTING) ||
               (m == `SLPC_MODE_ESTBY);
  endfunction

  // Mode keeps the system clock source running
  function automatic logic mode_sysosc(input logic [2:0] m);
    mode_sysosc = (m == `SLPC_MODE_IDLE) || (m == `SLPC_MODE_STANDBY_SETTING) ||
                  (m == `SLPC_MODE_ESTBY);
  endfunction

  // Wake sources allowed by the mode
  function automatic logic wake_ok(input logic [2:0] m, input logic [2:0] f,
                                   input logic irq, input logic rtc,
                                   input logic rtc_en);
    logic async_src;
    async_src = f[`SLPC_SYN_PORT] | f[`SLPC_SYN_TWI];
    if (m == `SLPC_MODE_IDLE) begin
      wake_ok = irq | async_src;
    end else if (mode_rtc(m)) begin
      wake_ok = async_src | (rtc & rtc_en);
    end else begin
      wake_ok = async_src;
    end
  endfunction

  logic       sleep_go;
  logic       wake_now;
  logic [2:0] syn_in;

  assign syn_in = {SYS_OSC_READY_I, TWO_WIRE_INTERFACE_MATCH_I, ASYNC_PORT_IRQ_I};
  // Entry needs the instruction, the enable bit and a defined code
  assign sleep_go = SLEEP_EXEC_I & SLEEP_ENABLE_BIT_I
                  & mode_valid(SLEEP_MODE_SELECT_I);
  assign wake_now = wake_ok(r_r.mode, r_r.flt, IRQ_ANY_I, RTC_IRQ_I,
                            RTC_ENABLE_I);

  // Next state of the sequencer and the input filters
  always_comb begin
    r_nxt       = r_r;
    r_nxt.wake  = 1'b0;
    r_nxt.syn_a = syn_in;
    r_nxt.syn_b = r_r.syn_a;
    r_nxt.syn_c = r_r.syn_b;
    for (int i = 0; i < `SLPC_SYN_W; i++) begin
      if (r_r.syn_b[i] == r_r.syn_c[i]) begin
        r_nxt.flt[i] = r_r.syn_c[i];
      end
    end
    case (r_r.st)
      slpc_pkg::ST_ACTIVE: begin
        if (sleep_go) begin
          r_nxt.st   = slpc_pkg::ST_SLEEP;
          r_nxt.mode = SLEEP_MODE_SELECT_I;
        end
      end
      slpc_pkg::ST_SLEEP: begin
        if (wake_now) begin
          r_nxt.cnt = 3'h0;
          if (mode_sysosc(r_r.mode)) begin
            r_nxt.st = slpc_pkg::ST_HALT;
          end else begin
            r_nxt.st = slpc_pkg::ST_OSCW;
          end
        end
      end
      slpc_pkg::ST_OSCW: begin
        if (r_r.flt[`SLPC_SYN_OSC]) begin
          r_nxt.st = slpc_pkg::ST_HALT;
        end
      end
      slpc_pkg::ST_HALT: begin
        r_nxt.cnt = r_r.cnt + 3'h1;
        if (r_r.cnt == `SLPC_HALT_CYC - 3'h1) begin
          r_nxt.st   = slpc_pkg::ST_RESUME;
          r_nxt.wake = 1'b1;
        end
      end
      slpc_pkg::ST_RESUME: begin
        r_nxt.st = slpc_pkg::ST_ACTIVE;
      end
      default: begin
        r_nxt.st = slpc_pkg::ST_ACTIVE;
      end
    endcase
  end

  // State register; reset returns straight to active from any mode
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  logic in_sleep;
  logic idle_sleep;
  assign in_sleep   = (r_r.st == slpc_pkg::ST_SLEEP);
  assign idle_sleep = in_sleep && (r_r.mode == `SLPC_MODE_IDLE);

  // Clock domain gating; only enables change, no state is cleared
  always_comb begin
    CLK_EN_O.cpu     = !in_sleep && (r_r.st != slpc_pkg::ST_OSCW);
    CLK_EN_O.nvm     = CLK_EN_O.cpu || NVM_BUSY_I;
    CLK_EN_O.per     = !in_sleep || idle_sleep;
    CLK_EN_O.rtc     = !in_sleep || idle_sleep ||
                       (mode_rtc(r_r.mode) && RTC_ENABLE_I);
    CLK_EN_O.rtc_osc = CLK_EN_O.rtc;
    CLK_EN_O.sys_osc = !in_sleep || mode_sysosc(r_r.mode);
  end

  // Per-peripheral gating freezes the peripheral by holding its clock
  assign PER_CLK_EN_O = {NPER{CLK_EN_O.per}} & ~PER_GATE_I;

  // Handshake to the core; the interrupt controller then orders service
  assign CPU_HALT_O    = (r_r.st == slpc_pkg::ST_HALT) ||
                         (r_r.st == slpc_pkg::ST_OSCW) || in_sleep;
  assign WAKE_RESUME_O = r_r.wake;
  assign SLEEPING_O    = in_sleep;

  // Entry only through the sleep instruction with enable set
  a_sleep_entry: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(SLEEPING_O) |-> $past(SLEEP_EXEC_I) && $past(SLEEP_ENABLE_BIT_I))
    else $error("sleep entered without instruction and enable");

  // Enable bit clear blocks sleep
  a_enable_gate: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (r_r.st == slpc_pkg::ST_ACTIVE) && SLEEP_EXEC_I && !SLEEP_ENABLE_BIT_I
    |=> !SLEEPING_O)
    else $error("sleep entered with enable bit clear");

  // Reserved code is a no-operation
  a_reserved_nop: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (r_r.st == slpc_pkg::ST_ACTIVE) && SLEEP_EXEC_I &&
    !mode_valid(SLEEP_MODE_SELECT_I) |=> (r_r.st == slpc_pkg::ST_ACTIVE))
    else $error("reserved mode code left active mode");

  // Four halted cycles then the resume pulse
  a_halt_four: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(r_r.st == slpc_pkg::ST_HALT) |->
    CPU_HALT_O [*4] ##1 (!CPU_HALT_O && WAKE_RESUME_O))
    else $error("halt after wake-up is not four cycles");

  // Resume returns to active next cycle
  a_resume_act: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    WAKE_RESUME_O |=> (r_r.st == slpc_pkg::ST_ACTIVE) && !WAKE_RESUME_O)
    else $error("resume pulse did not return to active");

  // Idle keeps peripherals, stops processor clock
  a_idle_clocks: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    idle_sleep |-> CLK_EN_O.per && !CLK_EN_O.cpu && CLK_EN_O.sys_osc)
    else $error("idle clock gating wrong");

  // Memory programming survives idle
  a_nvm_finish: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    NVM_BUSY_I |-> CLK_EN_O.nvm)
    else $error("memory clock stopped during programming");

  // Power-down stops peripheral, counter and system source clocks
  a_power_down_setting_clocks: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    in_sleep && (r_r.mode == `SLPC_MODE_POWER_DOWN_SETTING) |->
    !CLK_EN_O.per && !CLK_EN_O.rtc && !CLK_EN_O.rtc_osc && !CLK_EN_O.sys_osc)
    else $error("clock left running in power-down");

  // Plain interrupt does not wake power-down
  a_power_down_setting_wake: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    in_sleep && (r_r.mode == `SLPC_MODE_POWER_DOWN_SETTING) && !r_r.flt[0] && !r_r.flt[1]
    |=> SLEEPING_O)
    else $error("power-down woke on a disallowed source");

  // Idle wakes on any enabled interrupt
  a_idle_wake: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    idle_sleep && IRQ_ANY_I |=> (r_r.st == slpc_pkg::ST_HALT))
    else $error("idle did not wake on interrupt");

  // Stopped system source waits for its ready before the halt
  a_osc_wait: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(r_r.st == slpc_pkg::ST_HALT) && !mode_sysosc(r_r.mode) |->
    $past(r_r.st == slpc_pkg::ST_OSCW))
    else $error("wake skipped oscillator start-up");

  // Standby keeps the source, stops the counter
  a_standby_setting_clocks: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    in_sleep && (r_r.mode == `SLPC_MODE_STANDBY_SETTING) |->
    CLK_EN_O.sys_osc && !CLK_EN_O.rtc && !CLK_EN_O.per)
    else $error("standby clock gating wrong");

  // Gated peripheral has no clock
  a_per_gate: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (PER_CLK_EN_O & PER_GATE_I) == '0)
    else $error("gated peripheral still clocked");

endmodule

// [pkg/slpc_consts.svh]
// Constants for the sleep mode controller
`ifndef SLPC_CONSTS_SVH
`define SLPC_CONSTS_SVH

// Sleep mode select codes
`define SLPC_MODE_IDLE  3'h0
`define SLPC_MODE_POWER_DOWN_SETTING 3'h2
`define SLPC_MODE_POWER_SAVE_SETTING 3'h3
`define SLPC_MODE_STANDBY_SETTING 3'h6
`define SLPC_MODE_ESTBY 3'h7

// Processor halt after every wake-up, in clock cycles
`define SLPC_HALT_CYC   3'h4

// Positions of the synchronised wake and ready inputs
`define SLPC_SYN_PORT   0
`define SLPC_SYN_TWI    1
`define SLPC_SYN_OSC    2
`define SLPC_SYN_W      3

`endif

// [pkg/slpc_pkg.sv]
// Types for the sleep mode controller
package slpc_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_SLEEP  = 3'b001,
    ST_OSCW   = 3'b010,
    ST_HALT   = 3'b011,
    ST_RESUME = 3'b100
  } slpc_state_e;

  // Whole state of the controller
  typedef struct packed {
    slpc_state_e st;
    logic [2:0]  mode;
    logic [2:0]  cnt;
    logic [2:0]  syn_a;
    logic [2:0]  syn_b;
    logic [2:0]  syn_c;
    logic [2:0]  flt;
    logic        wake;
  } slpc_regs_s;

  // Clock domain and oscillator enables
  typedef struct packed {
    logic cpu;
    logic nvm;
    logic per;
    logic rtc;
    logic sys_osc;
    logic rtc_osc;
  } slpc_clk_s;

endpackage

// [tb/slpc_partner.sv]
// Clock generator model: system oscillator start-up after its enable
module slpc_partner #(
  parameter int STARTUP = 6
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic osc_en_i,
  output logic      ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Ready from reset, then only after STARTUP running cycles once restarted; lost at once when stopped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= STARTUP;
      ready_o <= 1'b1;
    end else if (!osc_en_i) begin
      cnt <= 0;
      ready_o <= 1'b0;
    end else begin
      if (cnt < STARTUP) cnt <= cnt + 1;
      ready_o <= (cnt >= STARTUP);
    end
  end
endmodule

// [tb/slpc_top_tb.sv]
// Self-checking bench for the sleep mode controller
`include "slpc_consts.svh"
module slpc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 6;
  typedef struct packed {
    logic [2:0] mode;
    logic [5:0] clk;
    logic [1:0] src;
  } slpc_row_s;
  logic                clk = 1'b0;
  logic                nrst = 1'b0;
  logic                exec = 1'b0;
  logic                en = 1'b1;
  logic                rtc_en = 1'b1;
  logic                nvm = 1'b0;
  logic                rdy;
  logic [2:0]          sel = 3'h0;
  logic [3:0]          wk = 4'h0;
  logic [7:0]          gate = 8'h00;
  logic                halt, resume, sleeping;
  logic [7:0]          pce;
  slpc_pkg::slpc_clk_s ce;
  int                  mismatches = 0;
  int                  n_tests = 0;
  int                  n_halt, n_all;
  // Mode, clock enables while asleep (RTC enabled, memory idle), wake source
  slpc_row_s rows [5] = '{'{`SLPC_MODE_IDLE, 6'h0F, 2'h0}, '{`SLPC_MODE_POWER_DOWN_SETTING, 6'h00, 2'h1},
                          '{`SLPC_MODE_POWER_SAVE_SETTING, 6'h05, 2'h3}, '{`SLPC_MODE_STANDBY_SETTING, 6'h02, 2'h2},
                          '{`SLPC_MODE_ESTBY, 6'h07, 2'h3}};

  slpc_top slpc_top_i (.CLK_I(clk), .NRST_I(nrst), .SLEEP_EXEC_I(exec),
    .SLEEP_MODE_SELECT_I(sel), .SLEEP_ENABLE_BIT_I(en), .CPU_HALT_O(halt),
    .WAKE_RESUME_O(resume), .SLEEPING_O(sleeping), .IRQ_ANY_I(wk[0]), .RTC_IRQ_I(wk[3]),
    .RTC_ENABLE_I(rtc_en), .ASYNC_PORT_IRQ_I(wk[1]), .TWO_WIRE_INTERFACE_MATCH_I(wk[2]),
    .NVM_BUSY_I(nvm), .SYS_OSC_READY_I(rdy), .PER_GATE_I(gate), .CLK_EN_O(ce),
    .PER_CLK_EN_O(pce));
  slpc_partner #(.STARTUP(ST)) slpc_partner_i (.clk_i(clk), .nrst_i(nrst),
    .osc_en_i(ce.sys_osc), .ready_o(rdy));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle sleep instruction with the given code and enable bit
  task automatic sleep(input logic [2:0] m, input logic e);
    @(posedge clk);
    sel <= m;
    en <= e;
    exec <= 1'b1;
    @(posedge clk);
    exec <= 1'b0;
    #1;
  endtask

  // Count halted cycles up to the resume pulse, bounded
  task automatic wake_wait();
    int i;
    n_halt = 0;
    n_all = 0;
    for (i = 0; i < 60 && resume !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (sleeping === 1'b0) n_all++;
      if (halt === 1'b1 && ce.cpu === 1'b1) n_halt++;
    end
    if (resume !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    #1;
    check("rst_clk_en", {2'h0, ce}, 8'h3F);
    check("rst_state", {5'h00, halt, sleeping, resume}, 8'h00);
    check("rst_per_en", pce, 8'hFF);
    foreach (rows[k]) begin
      sleep(rows[k].mode, 1'b1);
      check("sleeping", {7'h00, sleeping}, 8'h01);
      check("sleep_clk_en", {2'h0, ce}, {2'h0, rows[k].clk});
      if (rows[k].src != 2'h0) begin
        // Plain interrupt, plus counter interrupt where its source is stopped
        @(posedge clk);
        wk <= {~rows[k].clk[0], 3'h1};
        repeat (8) @(posedge clk);
        #1;
        check("no_wake", {7'h00, sleeping}, 8'h01);
      end
      @(posedge clk);
      wk[rows[k].src] <= 1'b1;
      wake_wait();
      check("halt_cycles", 8'(n_halt), 8'h04);
      check("osc_wait", 8'(n_all > 5), 8'(rows[k].clk[1] == 1'b0 && k != 0));
      @(posedge clk);
      wk <= 4'h0;
      #1;
      check("active_clk_en", {2'h0, ce}, 8'h3F);
      check("resume_pulse", {7'h00, resume}, 8'h00);
      repeat (5) @(posedge clk);
    end
    // Reserved codes and a cleared enable bit leave the device active
    foreach (rows[k]) begin
      if (k < 3) sleep(k == 0 ? 3'h1 : 3'h3 + 3'(k), 1'b1);
      if (k < 3) check("reserved", {7'h00, sleeping}, 8'h00);
    end
    sleep(`SLPC_MODE_IDLE, 1'b0);
    check("no_enable", {7'h00, sleeping}, 8'h00);
    // Power-save with the counter disabled: no counter clock, no counter wake
    @(posedge clk);
    rtc_en <= 1'b0;
    sleep(`SLPC_MODE_POWER_SAVE_SETTING, 1'b1);
    check("power_save_setting_rtc_off", {2'h0, ce}, 8'h00);
    @(posedge clk);
    wk[3] <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check("rtc_off_wake", {7'h00, sleeping}, 8'h01);
    @(posedge clk);
    wk <= 4'h2;
    wake_wait();
    check("rtc_off_halt", 8'(n_halt), 8'h04);
    check("rtc_off_osc", 8'(n_all > 5), 8'h01);
    @(posedge clk);
    wk <= 4'h0;
    rtc_en <= 1'b1;
    repeat (6) @(posedge clk);
    // Idle with programming in progress and gated peripherals
    @(posedge clk);
    nvm <= 1'b1;
    gate <= 8'hA5;
    sleep(`SLPC_MODE_IDLE, 1'b1);
    check("nvm_kept", {7'h00, ce.nvm}, 8'h01);
    check("per_gate", pce, 8'h5A);
    // A second instruction while asleep is ignored; the latched mode stays
    @(posedge clk);
    sel <= `SLPC_MODE_POWER_DOWN_SETTING;
    exec <= 1'b1;
    @(posedge clk);
    exec <= 1'b0;
    #1;
    check("mode_kept", {2'h0, ce}, 8'h1F);
    // Reset in mid-sleep restarts without a resume
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    #1;
    check("rst_sleep", {5'h00, halt, sleeping, resume}, 8'h00);
    check("rst_clk", {2'h0, ce}, 8'h3F);
    @(posedge clk);
    #1;
    check("rst_quiet", {5'h00, halt, sleeping, resume}, 8'h00);
    complete_run();
  end
endmodule
